// *** rsrp_top.v ***
// Reset and power-down retention policy with Avalon-MM registers
`timescale 1ns/1ps
`include "rsrp_defs.vh"

module rsrp_top (
   input wire mclk,
   input wire rst_n,
   input wire cal_rst_n,
   input wire nmi_level,
   input wire manual_reset_req,
   input wire sleep_req,
   input wire wake_req,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   output wire por_pin_ind,
   output wire por_wdt_ind,
   output wire manual_ind,
   output wire standby_ind,
   output wire sleep_ind
);

// ----------------------------------------
// Mode sequencer
// ----------------------------------------
localparam [4:0] ST_RUN = 5'h01;
localparam [4:0] ST_SLEEP = 5'h02;
localparam [4:0] ST_STBY = 5'h04;
localparam [4:0] ST_MRST = 5'h08;
localparam [4:0] ST_WPOR = 5'h10;

reg [4:0] state_r;
reg [4:0] state_nxt;
reg por_pin_r;
reg [2:0] cause_r;
reg waitreq_r;
reg [31:0] readdata_r;
reg [31:0] rd_mux;
reg [7:0] pre_div_r;
reg [7:0] cal_div_r;
reg [31:0] prog_counter_r;
reg [31:0] status_word_r;
reg [31:0] exception_event_code_r;
reg [31:0] translation_control_r;
reg [15:0] interrupt_control_r;
reg [31:0] vector_base_r;
reg [31:0] cache_control_r;
reg [31:0] break_address_b_r;
reg [15:0] break_control_r;
reg [15:0] break_bus_cycle_b_r;
reg [15:0] frequency_control_r;
reg [7:0] standby_control_r;
reg [7:0] watchdog_counter_r;
reg [7:0] watchdog_control_status_r;
reg [15:0] refresh_timer_control_r;
reg [15:0] refresh_timer_count_r;
reg [15:0] refresh_event_count_r;
reg [15:0] bus_control_1_r;
reg [15:0] bus_control_2_r;
reg [15:0] wait_control_1_r;
reg [15:0] wait_control_2_r;
reg [7:0] timer_start_register_r;
reg [31:0] timer_constant_r;
reg [31:0] timer_count_r;
reg [15:0] timer_control_r;
reg [7:0] sub_second_counter_r;
reg [7:0] seconds_counter_r;
reg [7:0] alarm_seconds_r;
reg [7:0] calendar_control_1_r;
reg [7:0] calendar_control_2_r;
reg [7:0] serial_mode_r;
reg [7:0] baud_rate_setting_r;
reg [7:0] serial_ctrl_r;
reg [7:0] transmit_holding_r;
reg [7:0] serial_status_reg_r;
reg [7:0] serial_port_pin_reg_r;
reg [7:0] smartcard_mode_reg_r;

wire st_run = state_r[0];
wire st_sleep = state_r[1];
wire st_stby = state_r[2];
wire st_mrst = state_r[3];
wire st_wpor = state_r[4];
wire por_any = por_pin_r | st_wpor;
wire rst_any = por_any | st_mrst;
wire wr_go = avs_write & ~waitreq_r & st_run;
wire [31:0] wd = avs_writedata;
wire pre_tick = (pre_div_r == `RSRP_PRE_DIV);
wire cal_tick = (cal_div_r == `RSRP_CAL_DIV);
wire wd_on = watchdog_control_status_r[`RSRP_WD_TME];
wire wd_rstmode = watchdog_control_status_r[`RSRP_WD_WTIT];
wire wdt_ovf = pre_tick & wd_on & (watchdog_counter_r == 8'hff);
wire wdt_rst = wdt_ovf & wd_rstmode;
wire wdt_man = watchdog_control_status_r[`RSRP_WD_RSTS];
wire cal_run = calendar_control_2_r[`RSRP_CC2_OSC] &
   calendar_control_2_r[`RSRP_CC2_START];
wire sec_carry = cal_tick & cal_run &
   (sub_second_counter_r == `RSRP_SUB_MAX);
wire alm_hit = sec_carry & alarm_seconds_r[`RSRP_ALM_ENB] &
   (alarm_seconds_r[6:0] == seconds_counter_r[6:0]);
wire tmr_cal = (timer_control_r[2:0] == `RSRP_TC_CAL);
wire tmr_tick = tmr_cal ? cal_tick : pre_tick;
wire tmr_ok = ~st_stby | tmr_cal;
wire tmr_go = timer_start_register_r[0] & tmr_tick & tmr_ok;
wire rf_go = pre_tick & ~st_stby & (refresh_timer_control_r[5:3] != 3'h0);
wire sci_act = serial_ctrl_r[`RSRP_SC_TE] | serial_ctrl_r[`RSRP_SC_RE];
wire sci_init = rst_any | st_stby | (st_sleep & ~sci_act);

assign avs_readdata = readdata_r;
assign avs_waitrequest = waitreq_r;
assign por_pin_ind = por_pin_r;
assign por_wdt_ind = st_wpor;
assign manual_ind = st_mrst;
assign standby_ind = st_stby;
assign sleep_ind = st_sleep;

always @* begin
   state_nxt = state_r;
   case (state_r)
      ST_RUN, ST_SLEEP, ST_STBY: begin
         if (wdt_rst)
            state_nxt = wdt_man ? ST_MRST : ST_WPOR;
         else if (manual_reset_req)
            state_nxt = ST_MRST;
         else if (st_run && sleep_req)
            state_nxt = standby_control_r[`RSRP_STB_STBY] ? ST_STBY : ST_SLEEP;
         else if (!st_run && wake_req)
            state_nxt = ST_RUN;
      end
      ST_MRST: begin
         if (!manual_reset_req)
            state_nxt = ST_RUN;
      end
      ST_WPOR: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
   endcase
end

always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      state_r <= ST_RUN;
      por_pin_r <= 1'b1;
      cause_r <= 3'h1;
      pre_div_r <= 8'h00;
   end else begin
      state_r <= state_nxt;
      por_pin_r <= 1'b0;
      pre_div_r <= pre_tick ? 8'h00 : pre_div_r + 8'h01;
      if (state_nxt == ST_WPOR)
         cause_r <= 3'h2;
      else if (state_nxt == ST_MRST)
         cause_r <= 3'h4;
   end
end

// ----------------------------------------
// Bus slave, one wait state per access
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      waitreq_r <= 1'b1;
      readdata_r <= 32'h0;
   end else if (!waitreq_r) begin
      waitreq_r <= 1'b1;
   end else if (avs_read || avs_write) begin
      waitreq_r <= 1'b0;
      readdata_r <= avs_read ? rd_mux : readdata_r;
   end
end

always @* begin
   case (avs_address)
      `RSRP_A_PC: rd_mux = prog_counter_r;
      `RSRP_A_SW: rd_mux = status_word_r;
      `RSRP_A_EXP: rd_mux = exception_event_code_r;
      `RSRP_A_MMU: rd_mux = translation_control_r;
      `RSRP_A_ICR: rd_mux = {16'h0, interrupt_control_r};
      `RSRP_A_VB: rd_mux = vector_base_r;
      `RSRP_A_CC: rd_mux = cache_control_r;
      `RSRP_A_BAB: rd_mux = break_address_b_r;
      `RSRP_A_BRC: rd_mux = {16'h0, break_control_r};
      `RSRP_A_BBC: rd_mux = {16'h0, break_bus_cycle_b_r};
      `RSRP_A_FRQ: rd_mux = {16'h0, frequency_control_r};
      `RSRP_A_STB: rd_mux = {24'h0, standby_control_r};
      `RSRP_A_WDC: rd_mux = {24'h0, watchdog_counter_r};
      `RSRP_A_WDS: rd_mux = {24'h0, watchdog_control_status_r};
      `RSRP_A_RTC: rd_mux = {16'h0, refresh_timer_control_r};
      `RSRP_A_RTN: rd_mux = {16'h0, refresh_timer_count_r};
      `RSRP_A_RFC: rd_mux = {16'h0, refresh_event_count_r};
      `RSRP_A_BC1: rd_mux = {16'h0, bus_control_1_r};
      `RSRP_A_BC2: rd_mux = {16'h0, bus_control_2_r};
      `RSRP_A_WC1: rd_mux = {16'h0, wait_control_1_r};
      `RSRP_A_WC2: rd_mux = {16'h0, wait_control_2_r};
      `RSRP_A_TST: rd_mux = {24'h0, timer_start_register_r};
      `RSRP_A_TCO: rd_mux = timer_constant_r;
      `RSRP_A_TCN: rd_mux = timer_count_r;
      `RSRP_A_TCR: rd_mux = {16'h0, timer_control_r};
      `RSRP_A_SUB: rd_mux = {24'h0, sub_second_counter_r};
      `RSRP_A_SEC: rd_mux = {24'h0, seconds_counter_r};
      `RSRP_A_ALM: rd_mux = {24'h0, alarm_seconds_r};
      `RSRP_A_CC1: rd_mux = {24'h0, calendar_control_1_r};
      `RSRP_A_CC2: rd_mux = {24'h0, calendar_control_2_r};
      `RSRP_A_SMD: rd_mux = {24'h0, serial_mode_r};
      `RSRP_A_BRT: rd_mux = {24'h0, baud_rate_setting_r};
      `RSRP_A_SCT: rd_mux = {24'h0, serial_ctrl_r};
      `RSRP_A_TXH: rd_mux = {24'h0, transmit_holding_r};
      `RSRP_A_SST: rd_mux = {24'h0, serial_status_reg_r};
      `RSRP_A_SPP: rd_mux = {24'h0, serial_port_pin_reg_r};
      `RSRP_A_SCM: rd_mux = {24'h0, smartcard_mode_reg_r};
      `RSRP_A_CAU: rd_mux = {24'h0, cause_r, state_r};
      default: rd_mux = 32'h0;
   endcase
end

// ----------------------------------------
// Core, translation, cache, interrupt, break
// ----------------------------------------
// Undefined-on-reset fields simply keep their value: cheapest legal choice
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      prog_counter_r <= `RSRP_PC_INIT;
      status_word_r <= `RSRP_SW_INIT;
      exception_event_code_r <= `RSRP_EXP_POR;
      translation_control_r <= 32'h0;
      interrupt_control_r <= `RSRP_ICR_LOW;
      vector_base_r <= 32'h0;
      cache_control_r <= 32'h0;
      break_address_b_r <= 32'h0;
      break_control_r <= 16'h0;
      break_bus_cycle_b_r <= 16'h0;
   end else if (rst_any) begin
      prog_counter_r <= `RSRP_PC_INIT;
      status_word_r <= status_word_r | `RSRP_SW_INIT;
      exception_event_code_r <= por_any ? `RSRP_EXP_POR
         : `RSRP_EXP_MAN;
      translation_control_r <= translation_control_r &
         `RSRP_MMU_KEEP;
      // Pin level cannot enter an async reset, so sample it here
      interrupt_control_r <= nmi_level ? `RSRP_ICR_NMI
         : `RSRP_ICR_LOW;
      vector_base_r <= 32'h0;
      cache_control_r <= 32'h0;
      break_control_r <= 16'h0;
      break_bus_cycle_b_r <= 16'h0;
   end else if (wr_go) begin
      // Writes only land in run mode, so power-down holds everything
      case (avs_address)
         `RSRP_A_PC: prog_counter_r <= wd;
         `RSRP_A_SW: status_word_r <= wd;
         `RSRP_A_EXP: exception_event_code_r <= wd;
         `RSRP_A_MMU: translation_control_r <= wd;
         `RSRP_A_ICR: interrupt_control_r <= wd[15:0];
         `RSRP_A_VB: vector_base_r <= wd;
         `RSRP_A_CC: cache_control_r <= wd;
         `RSRP_A_BAB: break_address_b_r <= wd;
         `RSRP_A_BRC: break_control_r <= wd[15:0];
         `RSRP_A_BBC: break_bus_cycle_b_r <= wd[15:0];
         default: ;
      endcase
   end
end

// ----------------------------------------
// Clock control and watchdog
// ----------------------------------------
// Only the pin reset touches these; watchdog power-on leaves them alone
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      frequency_control_r <= `RSRP_FRQ_INIT;
      standby_control_r <= 8'h00;
      watchdog_counter_r <= 8'h00;
      watchdog_control_status_r <= 8'h00;
   end else begin
      if (wr_go && avs_address == `RSRP_A_FRQ)
         frequency_control_r <= wd[15:0];
      if (wr_go && avs_address == `RSRP_A_STB)
         standby_control_r <= wd[7:0];
      if (wr_go && avs_address == `RSRP_A_WDC)
         watchdog_counter_r <= wd[7:0];
      else if (pre_tick && wd_on)
         watchdog_counter_r <= watchdog_counter_r + 8'h01;
      if (wr_go && avs_address == `RSRP_A_WDS)
         watchdog_control_status_r <= wd[7:0];
      // Overflow flag set after the write, so set beats clear
      if (wdt_ovf && wd_rstmode)
         watchdog_control_status_r[`RSRP_WD_WOVF] <= 1'b1;
      if (wdt_ovf && !wd_rstmode)
         watchdog_control_status_r[`RSRP_WD_IOVF] <= 1'b1;
   end
end

// ----------------------------------------
// Bus state control and refresh
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      bus_control_1_r <= 16'h0;
      bus_control_2_r <= `RSRP_BC2_INIT;
      wait_control_1_r <= `RSRP_WC1_INIT;
      wait_control_2_r <= `RSRP_WC2_INIT;
      refresh_timer_control_r <= 16'h0;
      refresh_timer_count_r <= 16'h0;
      refresh_event_count_r <= 16'h0;
   end else if (por_any) begin
      bus_control_1_r <= 16'h0;
      bus_control_2_r <= `RSRP_BC2_INIT;
      wait_control_1_r <= `RSRP_WC1_INIT;
      wait_control_2_r <= `RSRP_WC2_INIT;
      refresh_timer_control_r <= 16'h0;
      refresh_timer_count_r <= 16'h0;
      refresh_event_count_r <= 16'h0;
   end else begin
      case (wr_go ? avs_address : 8'h01)
         `RSRP_A_BC1: bus_control_1_r <= wd[15:0];
         `RSRP_A_BC2: bus_control_2_r <= wd[15:0];
         `RSRP_A_WC1: wait_control_1_r <= wd[15:0];
         `RSRP_A_WC2: wait_control_2_r <= wd[15:0];
         `RSRP_A_RTC: refresh_timer_control_r <= wd[15:0];
         `RSRP_A_RFC: refresh_event_count_r <= wd[15:0];
         default: ;
      endcase
      if (rf_go && refresh_timer_count_r == `RSRP_RF_LIMIT) begin
         refresh_timer_count_r <= 16'h0;
         refresh_event_count_r <= refresh_event_count_r + 16'h1;
      end else if (rf_go) begin
         refresh_timer_count_r <= refresh_timer_count_r + 16'h1;
      end
   end
end

// ----------------------------------------
// Timer unit, channel 0
// ----------------------------------------
// Calendar-clocked channel keeps counting in standby; others freeze
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      timer_start_register_r <= 8'h00;
      timer_constant_r <= `RSRP_TMR_INIT;
      timer_count_r <= `RSRP_TMR_INIT;
      timer_control_r <= 16'h0;
   end else if (rst_any) begin
      timer_start_register_r <= 8'h00;
      timer_constant_r <= `RSRP_TMR_INIT;
      timer_count_r <= `RSRP_TMR_INIT;
      timer_control_r <= 16'h0;
   end else begin
      if (wr_go && avs_address == `RSRP_A_TST)
         timer_start_register_r <= wd[7:0];
      if (wr_go && avs_address == `RSRP_A_TCO)
         timer_constant_r <= wd;
      if (wr_go && avs_address == `RSRP_A_TCR)
         timer_control_r <= wd[15:0];
      if (wr_go && avs_address == `RSRP_A_TCN)
         timer_count_r <= wd;
      else if (tmr_go && timer_count_r == 32'h0)
         timer_count_r <= timer_constant_r;
      else if (tmr_go)
         timer_count_r <= timer_count_r - 32'h1;
      if (tmr_go && timer_count_r == 32'h0)
         timer_control_r[`RSRP_TC_UNF] <= 1'b1;
   end
end

// ----------------------------------------
// Calendar, battery-backed part
// ----------------------------------------
// Own reset so no chip reset clears the seconds count
always @(posedge mclk or negedge cal_rst_n) begin
   if (!cal_rst_n) begin
      cal_div_r <= 8'h00;
      seconds_counter_r <= 8'h00;
      alarm_seconds_r <= 8'h00;
   end else begin
      cal_div_r <= cal_tick ? 8'h00 : cal_div_r + 8'h01;
      if (wr_go && avs_address == `RSRP_A_SEC)
         seconds_counter_r <= wd[7:0];
      else if (sec_carry)
         seconds_counter_r <= (seconds_counter_r == `RSRP_SEC_MAX) ? 8'h00
            : seconds_counter_r + 8'h01;
      if (por_any)
         alarm_seconds_r[`RSRP_ALM_ENB] <= 1'b0;
      else if (wr_go && avs_address == `RSRP_A_ALM)
         alarm_seconds_r <= wd[7:0];
   end
end

// ----------------------------------------
// Calendar, chip-reset part
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      sub_second_counter_r <= 8'h00;
      calendar_control_1_r <= 8'h00;
      calendar_control_2_r <= `RSRP_CC2_INIT;
   end else begin
      if (sec_carry)
         sub_second_counter_r <= 8'h00;
      else if (cal_tick && cal_run)
         sub_second_counter_r <= sub_second_counter_r + 8'h01;
      if (por_any)
         calendar_control_1_r <= 8'h00;
      else if (st_mrst)
         calendar_control_1_r <= calendar_control_1_r &
            `RSRP_CC1_KEEP;
      else if (wr_go && avs_address == `RSRP_A_CC1)
         calendar_control_1_r <= wd[7:0];
      if (sec_carry && !por_any)
         calendar_control_1_r[`RSRP_CC1_CF] <= 1'b1;
      if (alm_hit && !rst_any)
         calendar_control_1_r[`RSRP_CC1_AF] <= 1'b1;
      if (por_any)
         calendar_control_2_r <= `RSRP_CC2_INIT;
      else if (st_mrst)
         calendar_control_2_r <= calendar_control_2_r &
            `RSRP_CC2_INIT;
      else if (wr_go && avs_address == `RSRP_A_CC2)
         calendar_control_2_r <= wd[7:0];
   end
end

// ----------------------------------------
// Serial unit
// ----------------------------------------
// An active unit keeps its state through sleep except the smartcard mode bits; an idle one is reloaded
always @(posedge mclk or negedge rst_n) begin
   if (!rst_n) begin
      serial_mode_r <= 8'h00;
      baud_rate_setting_r <= `RSRP_FF_INIT;
      serial_ctrl_r <= 8'h00;
      transmit_holding_r <= `RSRP_FF_INIT;
      serial_status_reg_r <= `RSRP_SST_INIT;
      serial_port_pin_reg_r <= 8'h00;
      smartcard_mode_reg_r <= 8'h00;
   end else begin
      if (sci_init) begin
         serial_mode_r <= 8'h00;
         baud_rate_setting_r <= `RSRP_FF_INIT;
         serial_ctrl_r <= 8'h00;
         transmit_holding_r <= `RSRP_FF_INIT;
         serial_status_reg_r <= `RSRP_SST_INIT;
      end else begin
         case (wr_go ? avs_address : 8'h01)
            `RSRP_A_SMD: serial_mode_r <= wd[7:0];
            `RSRP_A_BRT: baud_rate_setting_r <= wd[7:0];
            `RSRP_A_SCT: serial_ctrl_r <= wd[7:0];
            `RSRP_A_TXH: transmit_holding_r <= wd[7:0];
            `RSRP_A_SST: serial_status_reg_r <= wd[7:0];
            default: ;
         endcase
      end
      if (por_any)
         serial_port_pin_reg_r <= serial_port_pin_reg_r &
            `RSRP_SPP_KEEP;
      else if (wr_go && avs_address == `RSRP_A_SPP)
         serial_port_pin_reg_r <= wd[7:0];
      if (rst_any || !st_run)
         smartcard_mode_reg_r <= smartcard_mode_reg_r &
            `RSRP_SCM_KEEP;
      else if (wr_go && avs_address == `RSRP_A_SCM)
         smartcard_mode_reg_r <= wd[7:0];
   end
end

endmodule

// *** rsrp_defs.vh ***
// Constants for the reset and retention policy block
`ifndef RSRP_DEFS_VH
`define RSRP_DEFS_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RSRP_A_PC 8'h00
`define RSRP_A_SW 8'h04
`define RSRP_A_EXP 8'h08
`define RSRP_A_MMU 8'h0c
`define RSRP_A_ICR 8'h10
`define RSRP_A_VB 8'h14
`define RSRP_A_CC 8'h18
`define RSRP_A_BAB 8'h1c
`define RSRP_A_BRC 8'h20
`define RSRP_A_BBC 8'h24
`define RSRP_A_FRQ 8'h28
`define RSRP_A_STB 8'h2c
`define RSRP_A_WDC 8'h30
`define RSRP_A_WDS 8'h34
`define RSRP_A_RTC 8'h38
`define RSRP_A_RTN 8'h3c
`define RSRP_A_RFC 8'h40
`define RSRP_A_BC1 8'h44
`define RSRP_A_BC2 8'h48
`define RSRP_A_WC1 8'h4c
`define RSRP_A_WC2 8'h50
`define RSRP_A_TST 8'h54
`define RSRP_A_TCO 8'h58
`define RSRP_A_TCN 8'h5c
`define RSRP_A_TCR 8'h60
`define RSRP_A_SUB 8'h64
`define RSRP_A_SEC 8'h68
`define RSRP_A_ALM 8'h6c
`define RSRP_A_CC1 8'h70
`define RSRP_A_CC2 8'h74
`define RSRP_A_SMD 8'h78
`define RSRP_A_BRT 8'h7c
`define RSRP_A_SCT 8'h80
`define RSRP_A_TXH 8'h84
`define RSRP_A_SST 8'h88
`define RSRP_A_SPP 8'h8c
`define RSRP_A_SCM 8'h90
`define RSRP_A_CAU 8'h94
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define RSRP_PC_INIT 32'ha0000000
`define RSRP_SW_INIT 32'h700000f0
`define RSRP_EXP_POR 32'h00000000
`define RSRP_EXP_MAN 32'h00000020
`define RSRP_MMU_KEEP 32'h00000100
`define RSRP_ICR_NMI 16'h8000
`define RSRP_ICR_LOW 16'h0000
`define RSRP_FRQ_INIT 16'h0102
`define RSRP_BC2_INIT 16'h3ffc
`define RSRP_WC1_INIT 16'h3fff
`define RSRP_WC2_INIT 16'hffff
`define RSRP_TMR_INIT 32'h0fffffff
`define RSRP_FF_INIT 8'hff
`define RSRP_SST_INIT 8'h84
`define RSRP_CC2_INIT 8'h09
`define RSRP_CC1_KEEP 8'h80
`define RSRP_SPP_KEEP 8'h05
`define RSRP_SCM_KEEP 8'hf2
// ----------------------------------------
// Bit positions and timing counts
// ----------------------------------------
`define RSRP_WD_TME 7
`define RSRP_WD_WTIT 6
`define RSRP_WD_RSTS 5
`define RSRP_WD_WOVF 4
`define RSRP_WD_IOVF 3
`define RSRP_STB_STBY 7
`define RSRP_ALM_ENB 7
`define RSRP_CC1_CF 7
`define RSRP_CC1_AF 0
`define RSRP_CC2_OSC 3
`define RSRP_CC2_START 0
`define RSRP_TC_UNF 8
`define RSRP_TC_CAL 3'h4
`define RSRP_SC_TE 5
`define RSRP_SC_RE 4
`define RSRP_PRE_DIV 8'hff
`define RSRP_CAL_DIV 8'hff
`define RSRP_RF_LIMIT 16'h00ff
`define RSRP_SEC_MAX 8'h3b
`define RSRP_SUB_MAX 8'h7f
`endif

// *** rsrp_top_assertions.sv ***
// Assertion checker for the reset retention policy top
`timescale 1ns/1ps
module rsrp_chk (
   input wire mclk,
   input wire rst_n,
   input wire cal_rst_n,
   input wire nmi_level,
   input wire manual_reset_req,
   input wire sleep_req,
   input wire wake_req,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [31:0] avs_readdata,
   input wire avs_waitrequest,
   input wire por_pin_ind,
   input wire por_wdt_ind,
   input wire manual_ind,
   input wire standby_ind,
   input wire sleep_ind
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // Sleep is only taken from run with no reset pending
   wire busy_mode = sleep_ind || standby_ind || manual_ind ||
      manual_reset_req || por_pin_ind || por_wdt_ind;
   sequence bus_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence low_pwr;
      sleep_ind || standby_ind;
   endsequence
   sequence awake;
      !sleep_ind && !standby_ind;
   endsequence
   wait_ans_a: assert property (bus_req |=> !avs_waitrequest)
      else $error("bus answer late");
   wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("ack longer than one cycle");
   por_once_a: assert property (por_pin_ind |-> ##[1:2] !por_pin_ind)
      else $error("pin reset flag stuck");
   por_stay_a: assert property (!por_pin_ind |=> !por_pin_ind)
      else $error("pin reset flag without reset");
   man_set_a: assert property ($rose(manual_reset_req) |->
      ##[1:2] manual_ind)
      else $error("manual flag missing");
   man_clr_a: assert property (!manual_reset_req [*3] |-> !manual_ind)
      else $error("manual flag without request");
   sleep_go_a: assert property (sleep_req && !busy_mode |->
      ##[1:2] low_pwr)
      else $error("power-down not entered");
   wake_go_a: assert property (wake_req ##0 low_pwr |-> ##[1:2] awake)
      else $error("wake ignored");
endmodule
bind rsrp_top rsrp_chk u_chk (.mclk(mclk), .rst_n(rst_n),
   .cal_rst_n(cal_rst_n), .nmi_level(nmi_level),
   .manual_reset_req(manual_reset_req),
   .sleep_req(sleep_req), .wake_req(wake_req), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .por_pin_ind(por_pin_ind), .por_wdt_ind(por_wdt_ind),
   .manual_ind(manual_ind), .standby_ind(standby_ind), .sleep_ind(sleep_ind));

// *** rsrp_top_tb.sv ***
// Self-checking bench for the reset retention policy top
`timescale 1ns/1ps
module rsrp_tb_top;
   logic mclk = 0, rst_n = 0, cal_rst_n = 0, nmi_level = 1;
   logic manual_reset_req = 0, sleep_req = 0, wake_req = 0;
   logic avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, v, w;
   wire avs_waitrequest, por_pin_ind, por_wdt_ind;
   wire manual_ind, standby_ind, sleep_ind;
   int err_total = 0, tests_run = 0, n = 0;
   // Address in the top byte, data or expected value below
   logic [39:0] rows [0:61] = '{40'h00a0000000, 40'h04700000f0,
      40'h0800000000, 40'h0c00000000, 40'h1000008000, 40'h1400000000,
      40'h1800000000, 40'h2000000000, 40'h2400000000, 40'h2800000102,
      40'h2c00000000, 40'h3000000000, 40'h3400000000, 40'h3800000000,
      40'h4000000000, 40'h4800003ffc, 40'h4c00003fff, 40'h500000ffff,
      40'h580fffffff, 40'h5c0fffffff, 40'h6000000000, 40'h7000000000,
      40'h7400000009, 40'h7c000000ff, 40'h8000000000, 40'h84000000ff,
      40'h8800000084, 40'h8c00000000, 40'h9000000000, 40'h9400000021,
      40'h5400000000, 40'h7800000000, 40'hfc00000000,
      40'h1412345678, 40'h1ccafe0000, 40'h4800001234, 40'h740000000e,
      40'h2c00000080,
      40'h1400000000, 40'h1ccafe0000, 40'h4800001234, 40'h7400000008,
      40'h2c00000080, 40'h00a0000000, 40'h0800000020, 40'h1000000000,
      40'h9400000081,
      40'h8000000030, 40'h7c00000012, 40'h3800000008, 40'h14000000ff,
      40'h1400000000, 40'h7c000000ff, 40'h8000000000, 40'h9400000084,
      40'h2800001234, 40'h30000000ff, 40'h34000000c0,
      40'h2800001234, 40'h34000000d0, 40'h0800000000, 40'h9400000041};
   rsrp_top uut (.mclk(mclk), .rst_n(rst_n), .cal_rst_n(cal_rst_n),
      .nmi_level(nmi_level), .manual_reset_req(manual_reset_req),
      .sleep_req(sleep_req), .wake_req(wake_req), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .por_pin_ind(por_pin_ind),
      .por_wdt_ind(por_wdt_ind), .manual_ind(manual_ind),
      .standby_ind(standby_ind), .sleep_ind(sleep_ind));
   always #2 mclk = ~mclk;
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until waitrequest is seen low at an edge
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do @(posedge mclk); while (avs_waitrequest !== 1'b0);
      v = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task run_rows(input int lo, input int hi, input logic wr);
      for (int i = lo; i <= hi; i++) begin
         bus(wr, rows[i][39:32], rows[i][31:0]);
         if (!wr) chk(v, rows[i][31:0]);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge mclk);
      chk(por_pin_ind, 32'h1);
      rst_n <= 1'b1;
      cal_rst_n <= 1'b1;
      run_rows(0, 32, 1'b0);
      $display("reset values done");
      run_rows(33, 37, 1'b1);
      nmi_level <= 1'b0;
      manual_reset_req <= 1'b1;
      repeat (3) @(posedge mclk);
      chk(manual_ind, 32'h1);
      manual_reset_req <= 1'b0;
      repeat (3) @(posedge mclk);
      run_rows(38, 46, 1'b0);
      $display("manual reset done");
      run_rows(47, 49, 1'b1);
      @(posedge mclk) sleep_req <= 1'b1;
      @(posedge mclk) sleep_req <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(standby_ind, 32'h1);
      run_rows(50, 50, 1'b1);
      run_rows(51, 54, 1'b0);
      // Refresh counter must not move while stopped
      bus(1'b0, 8'h3c, 32'h0);
      w = v;
      repeat (600) @(posedge mclk);
      bus(1'b0, 8'h3c, 32'h0);
      chk(v, w);
      @(posedge mclk) wake_req <= 1'b1;
      @(posedge mclk) wake_req <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(standby_ind, 32'h0);
      repeat (600) @(posedge mclk);
      bus(1'b0, 8'h3c, 32'h0);
      chk(v == w, 32'h0);
      bus(1'b1, 8'h2c, 32'h0);
      @(posedge mclk) sleep_req <= 1'b1;
      @(posedge mclk) sleep_req <= 1'b0;
      repeat (2) @(posedge mclk);
      chk(sleep_ind, 32'h1);
      $display("power-down done");
      @(posedge mclk) wake_req <= 1'b1;
      @(posedge mclk) wake_req <= 1'b0;
      run_rows(55, 57, 1'b1);
      // Counter preloaded to its last count so the overflow comes soon
      for (n = 0; n < 600 && por_wdt_ind !== 1'b1; n++) @(posedge mclk);
      chk(por_wdt_ind, 32'h1);
      @(posedge mclk);
      chk(por_wdt_ind, 32'h0);
      run_rows(58, 61, 1'b0);
      $display("watchdog reset done");
      conclude;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      conclude;
   end
endmodule
